// File: rtl/smbarp_pkg.sv
// Constants, encodings and state types shared by the SMBus ARP slave front end.
package smbarp_pkg;

  // Fixed bus addresses (7-bit form).
  localparam logic [6:0] ARP_DEV_ADDR = 7'h61; // Shared address of all ARP devices.
  localparam logic [6:0] FIXED_BASE = 7'h50; // Base of the strap-selected fixed address.

  // ARP command codes.
  localparam logic [7:0] CMD_PREPARE = 8'h01; // Prepare to ARP, general only.
  localparam logic [7:0] CMD_RESET = 8'h02; // Reset Device, general form.
  localparam logic [7:0] CMD_GET_UDID = 8'h03; // Get UDID, general form.
  localparam logic [7:0] CMD_ASSIGN = 8'h04; // Assign Address, general only.

  // Identifier field values.
  localparam logic [7:0] UDID_CAP = 8'hC1; // Capabilities: PEC, random-number device.
  localparam logic [7:0] UDID_VER = 8'h0A; // Version 1 and silicon revision.
  localparam logic [15:0] UDID_IFACE = 16'h0004; // Interface field.
  localparam logic [15:0] UDID_SUBSYS = 16'h0000; // Subsystem fields are unsupported.
  localparam logic [12:0] UDID_VS_ZERO = 13'h0000; // Zero bits above the strap bits.
  localparam logic [7:0] UDID_COUNT = 8'h11; // Byte count of a UDID block.
  localparam logic [7:0] NO_ADDR_BYTE = 8'hFF; // Address byte sent while no address is held.

  // Strap layout: bit 2 high selects ARP-capable mode, bits 1:0 pick the fixed address.
  localparam int STRAP_MODE_BIT = 2;
  localparam int STRAP_W = 3;

  // Byte positions inside ARP transfers, counted from the first byte after an address.
  localparam logic [5:0] IDX_CMD = 6'd1; // Command byte.
  localparam logic [5:0] IDX_UDID_FIRST = 6'd3; // First UDID byte of Assign Address.
  localparam logic [5:0] IDX_UDID_LAST = 6'd18; // Last UDID byte of Assign Address.
  localparam logic [5:0] IDX_NEW_ADDR = 6'd19; // Assigned address byte.
  localparam logic [5:0] LEN_SHORT = 6'd2; // Command plus PEC.
  localparam logic [5:0] LEN_ASSIGN = 6'd20; // Full Assign Address length with PEC.
  localparam logic [5:0] TX_IDX_COUNT = 6'd0; // Read byte that carries the count.
  localparam logic [5:0] TX_IDX_ADDR = 6'd17; // Read byte that carries the address.
  localparam logic [5:0] TX_IDX_PEC = 6'd18; // Read byte that carries the PEC.
  localparam logic [5:0] IDX_MAX = 6'h3F; // The byte counter saturates here.

  // Register access byte positions.
  localparam logic [5:0] IDX_PTR = 6'd1; // Pointer byte of a write.
  localparam logic [5:0] IDX_DATA = 6'd2; // Data byte of a write.

  // Bit engine.
  localparam logic [3:0] BITS_PER_BYTE = 4'd8;
  localparam logic [7:0] CRC_POLY = 8'h07; // PEC polynomial x^8+x^2+x+1.

  // Random generator.
  localparam logic [15:0] LFSR_SEED = 16'hACE1; // Non-zero start value.
  localparam logic [15:0] LFSR_TAPS = 16'hB400; // Galois taps on bits 15, 13, 12 and 10.

  // Link-side bit engine states.
  typedef enum logic [6:0] {
    LS_IDLE = 7'h01,
    LS_ADDR = 7'h02,
    LS_RX = 7'h04,
    LS_ACK = 7'h08,
    LS_TX = 7'h10,
    LS_RACK = 7'h20,
    LS_SKIP = 7'h40
  } smbarp_lstate_t;

endpackage : smbarp_pkg

// File: rtl/smbarp_slave.sv
// SMBus 2.0 slave front end with ARP, UDID and power-up strap sampling.
// Notes on behaviour
// (R1) Bus variant chosen by latched strap level.
// (R2) Eight strap levels pick mode, address, bits.
// (R3) Strap sampled once at power-up, then frozen.
// (R4) Fixed mode answers strap-derived address from start.
// (R5) Fixed mode works without any ARP exchange.
// (R6) ARP mode lets master assign address dynamically.
// (R7) ARP mode holds 128-bit UDID for master.
// (R8) Vendor-specific part comes from random generator.
// (R9) Latched strap level placed inside UDID.
// (R10) General always, Get UDID only while unresolved; directed only once address held.
// (R11) ARP traffic carries PEC; generated and checked.
// (R12) Prepare, Assign general; Reset, Get both forms.
// (R13) Others never use the two reserved addresses.
// (R14) First write byte loads the register pointer.
// (R15) Vendor field: strap bits plus 16 random bits.
// (R16) Fixed mode acknowledges Assign Address but never takes its address.
// (R17) Second write byte goes to pointed register.
// (R18) Read returns pointed register without pointer write.
// (R19) Random field fixed from power-up until reset.
`timescale 1ns/10ps
module smbarp_slave
  import smbarp_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID = 16'h5A5A, // Arbitrary value.
  parameter logic [15:0] DEVICE_ID = 16'h0101 // Arbitrary value.
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b,
  input wire logic [STRAP_W-1:0] strap_level,
  input wire logic strap_valid,
  input wire logic entropy_i,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  output logic arp_mode,
  output logic cfg_done,
  output logic addr_valid
);

  // System-domain state: strap capture, random source and register-side handshakes.
  typedef struct packed {
    logic ent_m; // Entropy synchroniser, first stage.
    logic ent_s; // Entropy synchroniser, second stage.
    logic [15:0] lfsr; // Free-running random generator.
    logic cfg_done; // Strap and random field have been latched.
    logic [STRAP_W-1:0] strap; // Latched strap level.
    logic [15:0] rnd; // Latched random field.
    logic arp_mode; // Latched bus variant.
    logic rq_m, rq_s, rq_p; // Read request toggle crossing.
    logic wt_m, wt_s, wt_p; // Write request toggle crossing.
    logic rd_pend; // Read data is captured on the next edge.
    logic [7:0] rd_hold; // Read data handed to the link side.
    logic ack_tgl; // Read answer toggle.
    logic [7:0] reg_addr; // Register address presented to the device.
    logic wr_en; // One-cycle register write strobe.
    logic [7:0] wr_data; // Register write data.
  } smbarp_sys_t;

  // Link-domain state: bit engine, pointer and ARP address state.
  typedef struct packed {
    logic scl_m, scl_s, scl_p; // Clock line synchroniser and history.
    logic sda_m, sda_s, sda_p; // Data line synchroniser and history.
    logic cfg_m, cfg_s; // Configuration-ready synchroniser.
    logic ack_m, ack_s, ack_p; // Read answer toggle synchroniser.
    smbarp_lstate_t st; // Bit engine state.
    logic [3:0] bitcnt; // Bits of the current byte.
    logic [7:0] shreg; // Byte shift register.
    logic [5:0] idx; // Bytes since the last address byte.
    logic in_txn; // Between a start and its stop.
    logic is_rd; // Current address byte asked for a read.
    logic is_arp; // Current address is the ARP address.
    logic nack; // Master refused the last transmitted byte.
    logic udid_mis; // Assign Address identifier did not match.
    logic [7:0] cmd; // ARP command byte.
    logic [7:0] ptr; // The register_pointer.
    logic [7:0] crc; // Running PEC.
    logic [7:0] new_addr; // Address byte of Assign Address.
    logic [7:0] rdata; // Register byte for reads.
    logic [7:0] wdata; // Register byte for writes.
    logic ar; // Address resolved flag.
    logic av; // Address valid flag.
    logic [6:0] dyn_addr; // Assigned address.
    logic rq_tgl; // Read request toggle.
    logic wr_tgl; // Write request toggle.
    logic sda_oe_b; // Low while pulling the data line low.
  } smbarp_link_t;

  smbarp_sys_t s_reg, s_next;
  smbarp_link_t l_reg, l_next;

  // PEC update over one byte, used for every received and sent byte.
  function automatic logic [7:0] smbarp_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    return x;
  endfunction : smbarp_crc8

  // Byte k of the identifier, most significant byte first.
  function automatic logic [7:0] smbarp_udid_byte(input logic [127:0] u, input logic [3:0] k);
    return u[7'(7'd127 - {k, 3'b000}) -: 8];
  endfunction : smbarp_udid_byte

  // Identifier assembled from constants and the latched strap and random values.
  logic [127:0] udid;
  assign udid = {UDID_CAP, UDID_VER, VENDOR_ID, DEVICE_ID, UDID_IFACE, UDID_SUBSYS,
                 UDID_SUBSYS, UDID_VS_ZERO, s_reg.strap, s_reg.rnd}; // R7 R9 R15

  // System domain next state.
  always_comb begin
    s_next = s_reg;
    s_next.ent_m = entropy_i;
    s_next.ent_s = s_reg.ent_m;
    // Galois shift with the noise bit folded in, so identical parts drift apart.
    s_next.lfsr = {s_reg.lfsr[14:0], 1'b0} ^ (s_reg.lfsr[15] ? LFSR_TAPS : 16'h0000)
                  ^ {15'h0000, s_reg.ent_s}; // R8
    // The first digitised strap level after reset is kept until the next reset.
    if (!s_reg.cfg_done && strap_valid) begin
      s_next.cfg_done = 1'b1; // R3
      s_next.strap = strap_level; // R2
      s_next.arp_mode = strap_level[STRAP_MODE_BIT]; // R1
      s_next.rnd = s_reg.lfsr; // R19
    end
    s_next.rq_m = l_reg.rq_tgl;
    s_next.rq_s = s_reg.rq_m;
    s_next.rq_p = s_reg.rq_s;
    s_next.wt_m = l_reg.wr_tgl;
    s_next.wt_s = s_reg.wt_m;
    s_next.wt_p = s_reg.wt_s;
    s_next.wr_en = 1'b0;
    s_next.rd_pend = 1'b0;
    // A read request presents the pointer, then captures the answer a cycle later.
    if (s_reg.rq_s != s_reg.rq_p) begin
      s_next.reg_addr = l_reg.ptr; // R18
      s_next.rd_pend = 1'b1;
    end
    if (s_reg.rd_pend) begin
      s_next.rd_hold = reg_rd_data;
      s_next.ack_tgl = ~s_reg.ack_tgl;
    end
    // A write request becomes one strobe with the pointer and data bytes.
    if (s_reg.wt_s != s_reg.wt_p) begin
      s_next.wr_en = 1'b1; // R17
      s_next.reg_addr = l_reg.ptr;
      s_next.wr_data = l_reg.wdata;
    end
  end

  // System domain registers.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.lfsr <= LFSR_SEED;
    end else begin
      s_reg <= s_next;
    end
  end

  // Link-side decode helpers.
  logic scl_rise, scl_fall, bus_start, bus_stop, fd_mode, own_hit, arp_hit, gud_ok;
  logic [6:0] own_addr;
  logic [5:0] idx_inc;
  logic [7:0] txb;
  assign scl_rise = l_reg.scl_s & ~l_reg.scl_p;
  assign scl_fall = ~l_reg.scl_s & l_reg.scl_p;
  assign bus_start = l_reg.scl_s & l_reg.scl_p & l_reg.sda_p & ~l_reg.sda_s;
  assign bus_stop = l_reg.scl_s & l_reg.scl_p & ~l_reg.sda_p & l_reg.sda_s;
  assign fd_mode = ~s_reg.strap[STRAP_MODE_BIT]; // R1
  // Fixed mode needs no ARP exchange; ARP mode waits for an assigned address.
  assign own_addr = fd_mode ? (FIXED_BASE | {5'h00, s_reg.strap[1:0]}) : l_reg.dyn_addr; // R4 R5
  assign own_hit = (fd_mode | l_reg.av) & (l_reg.shreg[7:1] == own_addr); // R6
  assign arp_hit = l_reg.shreg[7:1] == ARP_DEV_ADDR;
  // Get UDID: general while unresolved, directed only to the held address.
  assign gud_ok = ((l_reg.cmd == CMD_GET_UDID) & ~l_reg.ar)
                | (l_reg.av & (l_reg.cmd == {l_reg.dyn_addr, 1'b1})); // R10 R12
  assign idx_inc = (l_reg.idx == IDX_MAX) ? IDX_MAX : 6'(l_reg.idx + 6'd1);

  // Byte to send next: UDID block for ARP reads, register contents otherwise.
  always_comb begin
    txb = l_reg.rdata; // R18
    if (l_reg.is_arp) begin
      if (l_reg.idx == TX_IDX_COUNT) begin
        txb = UDID_COUNT;
      end else if (l_reg.idx < TX_IDX_ADDR) begin
        txb = smbarp_udid_byte(udid, 4'(l_reg.idx - 6'd1)); // R7
      end else if (l_reg.idx == TX_IDX_ADDR) begin
        txb = l_reg.av ? {l_reg.dyn_addr, 1'b1} : NO_ADDR_BYTE;
      end else begin
        txb = l_reg.crc; // R11
      end
    end
  end

  // Link domain next state: line sampling, bit engine and ARP commands.
  always_comb begin
    l_next = l_reg;
    l_next.scl_m = scl_i;
    l_next.scl_s = l_reg.scl_m;
    l_next.scl_p = l_reg.scl_s;
    l_next.sda_m = sda_i;
    l_next.sda_s = l_reg.sda_m;
    l_next.sda_p = l_reg.sda_s;
    l_next.cfg_m = s_reg.cfg_done;
    l_next.cfg_s = l_reg.cfg_m;
    l_next.ack_m = s_reg.ack_tgl;
    l_next.ack_s = l_reg.ack_m;
    l_next.ack_p = l_reg.ack_s;
    // Read answers are taken once the toggle has crossed.
    if (l_reg.ack_s != l_reg.ack_p) begin
      l_next.rdata = s_reg.rd_hold;
    end
    if (!l_reg.cfg_s) begin
      // Until the strap is latched the bus is ignored and the data line is released.
      l_next.st = LS_IDLE;
      l_next.sda_oe_b = 1'b1;
    end else if (bus_start) begin
      // A repeated start keeps the running PEC of the write part.
      l_next.st = LS_ADDR;
      l_next.bitcnt = 4'd0;
      l_next.sda_oe_b = 1'b1;
      l_next.in_txn = 1'b1;
      if (!l_reg.in_txn) begin
        l_next.crc = 8'h00;
      end
    end else if (bus_stop) begin
      // ARP writes act at the stop, and only with a correct PEC.
      if (l_reg.is_arp && !l_reg.is_rd && l_reg.crc == 8'h00) begin // R11
        if (l_reg.idx == LEN_SHORT) begin
          if (l_reg.cmd == CMD_PREPARE) begin
            l_next.ar = 1'b0; // R12
          end else if (l_reg.cmd == CMD_RESET
                       || (l_reg.av && l_reg.cmd == {l_reg.dyn_addr, 1'b0})) begin
            l_next.ar = 1'b0; // R10 R12
            l_next.av = 1'b0;
          end
        end else if (l_reg.idx == LEN_ASSIGN && l_reg.cmd == CMD_ASSIGN
                     && !l_reg.udid_mis && !fd_mode) begin
          l_next.dyn_addr = l_reg.new_addr[7:1]; // R6 R16
          l_next.ar = 1'b1;
          l_next.av = 1'b1;
        end
      end
      l_next.st = LS_IDLE;
      l_next.in_txn = 1'b0;
      l_next.is_arp = 1'b0;
      l_next.cmd = 8'h00;
      l_next.udid_mis = 1'b0;
      l_next.sda_oe_b = 1'b1;
    end else begin
      case (l_reg.st)
        LS_ADDR, LS_RX: begin
          if (scl_rise && l_reg.bitcnt < BITS_PER_BYTE) begin
            l_next.shreg = {l_reg.shreg[6:0], l_reg.sda_s};
            l_next.bitcnt = l_reg.bitcnt + 4'd1;
          end else if (scl_fall && l_reg.bitcnt == BITS_PER_BYTE) begin
            if (l_reg.st == LS_ADDR) begin
              // Address byte: acknowledge the ARP address or our own address.
              if ((arp_hit && (!l_reg.shreg[0] || gud_ok)) || (!arp_hit && own_hit)) begin
                l_next.is_arp = arp_hit;
                l_next.is_rd = l_reg.shreg[0];
                l_next.idx = 6'd0;
                l_next.crc = smbarp_crc8(l_reg.crc, l_reg.shreg); // R11
                l_next.rq_tgl = l_reg.rq_tgl ^ (~arp_hit & l_reg.shreg[0]); // R18
                l_next.st = LS_ACK;
                l_next.sda_oe_b = 1'b0;
              end else begin
                l_next.st = LS_SKIP;
              end
            end else begin
              // Data byte from the master.
              l_next.idx = idx_inc;
              l_next.crc = smbarp_crc8(l_reg.crc, l_reg.shreg); // R11
              if (l_reg.is_arp) begin
                if (idx_inc == IDX_CMD) begin
                  l_next.cmd = l_reg.shreg;
                end else if (idx_inc >= IDX_UDID_FIRST && idx_inc <= IDX_UDID_LAST) begin
                  if (l_reg.shreg != smbarp_udid_byte(udid, 4'(idx_inc - IDX_UDID_FIRST))) begin
                    l_next.udid_mis = 1'b1;
                  end
                end else if (idx_inc == IDX_NEW_ADDR) begin
                  l_next.new_addr = l_reg.shreg;
                end
              end else if (idx_inc == IDX_PTR) begin
                l_next.ptr = l_reg.shreg; // R14
              end else if (idx_inc == IDX_DATA) begin
                l_next.wdata = l_reg.shreg; // R17
                l_next.wr_tgl = ~l_reg.wr_tgl;
              end
              l_next.st = LS_ACK;
              l_next.sda_oe_b = 1'b0;
            end
          end
        end
        LS_ACK, LS_RACK: begin
          if (l_reg.st == LS_RACK && scl_rise) begin
            l_next.nack = l_reg.sda_s;
          end else if (scl_fall) begin
            l_next.bitcnt = 4'd0;
            if (l_reg.st == LS_RACK && l_reg.nack) begin
              // Master refused more data; release and wait for the stop.
              l_next.st = LS_SKIP;
              l_next.sda_oe_b = 1'b1;
            end else if (l_reg.is_rd) begin
              // Load the next byte and put its first bit on the line.
              l_next.shreg = txb;
              l_next.sda_oe_b = txb[7];
              l_next.crc = smbarp_crc8(l_reg.crc, txb); // R11
              l_next.idx = idx_inc;
              l_next.st = LS_TX;
            end else begin
              l_next.sda_oe_b = 1'b1;
              l_next.st = LS_RX;
            end
          end
        end
        LS_TX: begin
          if (scl_rise) begin
            l_next.bitcnt = l_reg.bitcnt + 4'd1;
          end else if (scl_fall) begin
            if (l_reg.bitcnt == BITS_PER_BYTE) begin
              l_next.st = LS_RACK;
              l_next.sda_oe_b = 1'b1;
            end else begin
              l_next.shreg = {l_reg.shreg[6:0], 1'b0};
              l_next.sda_oe_b = l_reg.shreg[6];
            end
          end
        end
        default: begin
          // Idle or not addressed: the line stays released.
          l_next.sda_oe_b = 1'b1;
        end
      endcase
    end
  end

  // Link domain registers.
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      l_reg <= '0;
      l_reg.scl_m <= 1'b1;
      l_reg.scl_s <= 1'b1;
      l_reg.scl_p <= 1'b1;
      l_reg.sda_m <= 1'b1;
      l_reg.sda_s <= 1'b1;
      l_reg.sda_p <= 1'b1;
      l_reg.st <= LS_IDLE;
      l_reg.sda_oe_b <= 1'b1;
    end else begin
      l_reg <= l_next;
    end
  end

  // Outputs taken from flip-flops, except sda_o which is tied low; the data pin only ever pulls low.
  assign sda_o = 1'b0;
  assign sda_oe_b = l_reg.sda_oe_b;
  assign reg_addr = s_reg.reg_addr;
  assign reg_wr_en = s_reg.wr_en;
  assign reg_wr_data = s_reg.wr_data;
  assign arp_mode = s_reg.arp_mode;
  assign cfg_done = s_reg.cfg_done;
  assign addr_valid = l_reg.av;

  // Checks on the system domain.
  chk_strap_frozen: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
    $past(s_reg.cfg_done) |-> $stable(s_reg.strap) && $stable(s_reg.arp_mode))
    else $error("Strap level changed after it was latched.");
  chk_rnd_held: assert property (@(posedge clk_sys) disable iff (!rst_b) // R19
    s_reg.cfg_done |=> s_reg.cfg_done && $stable(s_reg.rnd))
    else $error("Random field changed after power-up.");
  chk_strap_take: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
    !s_reg.cfg_done && strap_valid |=> s_reg.cfg_done && s_reg.strap == $past(strap_level)
      && s_reg.arp_mode == $past(strap_level[STRAP_MODE_BIT]) && s_reg.rnd == $past(s_reg.lfsr))
    else $error("Strap level not latched on its first valid cycle.");
  chk_udid_vendor: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
    $rose(s_reg.cfg_done) |-> udid[31:0]
      == {UDID_VS_ZERO, $past(strap_level), $past(s_reg.lfsr)})
    else $error("Vendor field does not carry strap bits and random value.");
  chk_wr_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b) // R17
    s_reg.wt_s != s_reg.wt_p |=> reg_wr_en && reg_wr_data == l_reg.wdata ##1 !reg_wr_en)
    else $error("Register write strobe missing or stretched.");

  // Checks on the link domain.
  chk_ptr_load: assert property (@(posedge link_clk) disable iff (!rst_b) // R14
    l_reg.cfg_s && !bus_start && !bus_stop && l_reg.st == LS_RX && !l_reg.is_arp
      && scl_fall && l_reg.bitcnt == BITS_PER_BYTE && l_reg.idx == 6'd0
      |=> l_reg.ptr == $past(l_reg.shreg) && l_reg.st == LS_ACK && !sda_oe_b)
    else $error("Pointer byte not stored and acknowledged.");
  chk_fd_no_assign: assert property (@(posedge link_clk) disable iff (!rst_b) // R16
    l_reg.cfg_s && fd_mode |=> $stable(l_reg.dyn_addr) && !l_reg.av)
    else $error("Address assigned while in fixed mode.");
  chk_directed_gate: assert property (@(posedge link_clk) disable iff (!rst_b) // R10
    $rose(l_reg.av) |-> $past(l_reg.cmd) == CMD_ASSIGN && $past(bus_stop)
      && $past(l_reg.crc) == 8'h00)
    else $error("Address became valid without a checked Assign Address.");
  chk_idle_release: assert property (@(posedge link_clk) disable iff (!rst_b) // R4
    !l_reg.cfg_s |=> sda_oe_b [*2])
    else $error("Data line driven before the strap was latched.");

endmodule : smbarp_slave

// File: verification/smbarp_host.sv
// SMBus host model that drives the bus clock and data line.
`timescale 1ns/10ps
module smbarp_host
  import smbarp_pkg::*;
(
  output logic scl,
  output logic sda_h,
  input wire logic sda
);
  localparam int T_Q = 150; // Third of a bit time in ns, over two link periods so each level is seen.
  logic [7:0] pec; // Running check byte of the current transfer.
  // The bus idles released, both lines high.
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
    pec = 8'h00;
  end
  // Folds one byte into the running check byte.
  task automatic crc(input logic [7:0] b);
    pec = pec ^ b;
    for (int i = 0; i < 8; i++) begin
      pec = pec[7] ? {pec[6:0], 1'b0} ^ CRC_POLY : {pec[6:0], 1'b0};
    end
  endtask : crc
  // A repeated start keeps the check byte running.
  task automatic start(input logic rep);
    if (!rep) pec = 8'h00;
    #T_Q sda_h = 1'b1;
    #T_Q scl = 1'b1;
    #T_Q sda_h = 1'b0;
    #T_Q scl = 1'b0;
  endtask : start
  // Stop, then bus free time.
  task automatic stop();
    #T_Q sda_h = 1'b0;
    #T_Q scl = 1'b1;
    #T_Q sda_h = 1'b1;
    #(4 * T_Q);
  endtask : stop
  // Data changes in the low phase and is sampled in the high phase.
  task automatic bit_io(input logic b, output logic r);
    #T_Q sda_h = b;
    #T_Q scl = 1'b1;
    #T_Q r = sda;
    scl = 1'b0;
  endtask : bit_io
  // Sends a byte MSB first and returns the acknowledge.
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    crc(b);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr
  // Reads a byte and acknowledges it unless it is the last.
  task automatic rd(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    crc(b);
    bit_io(last, r);
  endtask : rd
endmodule : smbarp_host

// File: verification/smbarp_slave_test.sv
// Self-checking bench for the SMBus slave front end.
`timescale 1ns/10ps
module smbarp_slave_test
  import smbarp_pkg::*;
;
  logic clk_sys, rst_b, link_clk, scl, sda_h, sda_o, sda_oe_b, strap_valid, ack;
  logic entropy_i = 1'b0; // Noise bit, toggled on every system clock while scl is low.
  logic [2:0] strap_level;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, wa, wd, b;
  logic reg_wr_en, arp_mode, cfg_done, addr_valid;
  logic [7:0] udid [0:18]; // Count, sixteen identifier bytes, address, check byte.
  int num_errors, cmp_count;
  int wn = 0; // Register writes seen.
  wire sda = sda_h & (sda_oe_b | sda_o); // Pulled-up open-drain data line.
  assign reg_rd_data = reg_addr ^ 8'h3C; // Register file stand-in.
  smbarp_host u_smbarp_host (.scl(scl), .sda_h(sda_h), .sda(sda));
  smbarp_slave u_smbarp_slave (.clk_sys(clk_sys), .rst_b(rst_b), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b),
    .strap_level(strap_level), .strap_valid(strap_valid), .entropy_i(entropy_i),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .arp_mode(arp_mode), .cfg_done(cfg_done),
    .addr_valid(addr_valid));
  // Clocks: system 8 ns, link 64 ns with an offset phase.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #32 link_clk = ~link_clk;
  end
  // Noise input toggles while scl is low.
  always @(posedge clk_sys) entropy_i <= ~entropy_i ^ scl;
  // Records register writes.
  always @(posedge clk_sys) begin
    if (reg_wr_en === 1'b1) begin
      wa <= reg_addr;
      wd <= reg_wr_data;
      wn <= wn + 1;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] v);
    u_smbarp_host.wr(v, ack);
  endtask : wr
  // Resets with a strap level and waits for the configuration to settle.
  task automatic power_up(input logic [2:0] lvl);
    int n;
    @(posedge clk_sys);
    rst_b <= 1'b0;
    strap_level <= ~lvl;
    strap_valid <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    // A level that stands before the converter is valid must not be taken.
    repeat (3) @(posedge clk_sys);
    strap_level <= lvl;
    strap_valid <= 1'b1;
    for (n = 0; n < 50 && cfg_done !== 1'b1; n++) @(posedge clk_sys);
    check(n < 50, 1'b1);
    if (n == 50) complete_run();
    // A later strap change must leave the latched level alone.
    strap_level <= ~lvl;
    repeat (40) @(posedge clk_sys);
    check(arp_mode, lvl[2]);
  endtask : power_up
  // ARP command with only a command byte.
  task automatic short_cmd(input logic [7:0] c);
    u_smbarp_host.start(1'b0);
    wr({ARP_DEV_ADDR, 1'b0});
    wr(c);
    wr(u_smbarp_host.pec);
    u_smbarp_host.stop();
  endtask : short_cmd
  task automatic assign_addr(input logic [6:0] a);
    u_smbarp_host.start(1'b0);
    wr({ARP_DEV_ADDR, 1'b0});
    wr(CMD_ASSIGN);
    wr(UDID_COUNT);
    for (int i = 1; i < 17; i++) wr(udid[i]);
    wr({a, 1'b0});
    wr(u_smbarp_host.pec);
    u_smbarp_host.stop();
  endtask : assign_addr
  task automatic get_udid(input logic [7:0] cmd, input logic [7:0] ab, input logic [2:0] lvl);
    u_smbarp_host.start(1'b0);
    wr({ARP_DEV_ADDR, 1'b0});
    wr(cmd);
    u_smbarp_host.start(1'b1);
    wr({ARP_DEV_ADDR, 1'b1});
    check(ack, 1'b1);
    for (int i = 0; i < 19; i++) u_smbarp_host.rd(i == 18, udid[i]);
    u_smbarp_host.stop();
    check(u_smbarp_host.pec, 8'h00);
    check(udid[0], UDID_COUNT);
    check(udid[1], UDID_CAP);
    check(udid[13], 8'h00);
    check(udid[14], {5'h00, lvl});
    check(udid[17], ab);
  endtask : get_udid
  // ARP mode: identify, assign, reach the new address, reset.
  task automatic arp_flow();
    logic [7:0] r0;
    power_up(3'b101);
    short_cmd(CMD_PREPARE);
    get_udid(CMD_GET_UDID, NO_ADDR_BYTE, 3'b101);
    r0 = udid[16];
    assign_addr(7'h30);
    check(addr_valid, 1'b1);
    get_udid(8'h61, 8'h61, 3'b101);
    check(udid[16], r0);
    u_smbarp_host.start(1'b0);
    wr(8'h60);
    u_smbarp_host.stop();
    check(ack, 1'b1);
    short_cmd(8'h60);
    check(addr_valid, 1'b0);
    assign_addr(7'h30);
    check(addr_valid, 1'b1);
    short_cmd(CMD_RESET);
    check(addr_valid, 1'b0);
  endtask : arp_flow
  // Fixed mode: strap address, pointer write, read back, ignored assignment.
  task automatic fixed_flow();
    power_up(3'b001);
    u_smbarp_host.start(1'b0);
    wr(8'hA2);
    check(ack, 1'b1);
    wr(8'h20);
    wr(8'hA5);
    u_smbarp_host.stop();
    check(wn, 1);
    check(wa, 8'h20);
    check(wd, 8'hA5);
    @(posedge clk_sys);
    strap_level <= 3'b110;
    u_smbarp_host.start(1'b0);
    wr(8'hA3);
    u_smbarp_host.rd(1'b1, b);
    u_smbarp_host.stop();
    check(b, 8'h1C);
    check(arp_mode, 1'b0);
    get_udid(CMD_GET_UDID, NO_ADDR_BYTE, 3'b001);
    assign_addr(7'h30);
    check(addr_valid, 1'b0);
    u_smbarp_host.start(1'b0);
    wr(8'hA0);
    u_smbarp_host.stop();
    check(ack, 1'b0);
  endtask : fixed_flow
  initial begin
    rst_b = 1'b0;
    strap_level = 3'h0;
    strap_valid = 1'b0;
    arp_flow();
    fixed_flow();
    complete_run();
  end
endmodule : smbarp_slave_test
